// ---- include/cas_map_pkg.sv ----
// Constants shared by the CAS voice signaling mapper.
// Assumes ABCD nibbles are carried with A in the top bit and D in the bottom bit.
package cas_map_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int ABCD_W = 4;

  // ABCD bit positions inside a nibble
  localparam int BIT_A = 3;
  localparam int BIT_B = 2;

  // Register word addresses
  localparam logic [ADDR_W-1:0] ADDR_STATION_CFG = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_OFFICE_CFG = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h2;

  // Configuration field positions (both port configs share the layout)
  localparam int CFG_RX_SEL_B = 0;
  localparam int CFG_RX_INV = 1;
  localparam int CFG_TX_SEL_B = 2;
  localparam int CFG_TX_INV = 3;
  localparam int CFG_POL_EN = 4;
  localparam int CFG_FEEDBACK = 5;
  localparam int CFG_OOS_OFF_HOOK = 6;
  localparam int CFG_DEF_LSB = 8;
  localparam int CFG_DEF_MSB = 11;

  // Status field positions
  localparam int ST_STATION_HOOK = 0;
  localparam int ST_STATION_POL = 1;
  localparam int ST_OFFICE_HOOK = 2;
  localparam int ST_OFFICE_POL = 3;
  localparam int ST_OOS = 4;
  localparam int ST_LAW_A = 5;

  // Reset values of the default fill patterns
  localparam logic [ABCD_W-1:0] STATION_DEF_RST = 4'h1;
  localparam logic [ABCD_W-1:0] OFFICE_DEF_RST = 4'h0;

  // Companding law code: only A-law exists on E1
  localparam logic LAW_A = 1'b1;

  typedef enum logic {OOS_HOLD_ON_HOOK, OOS_HOLD_OFF_HOOK} oos_method_t;
endpackage

// ---- rtl/cas_voice_signaling_mapper.sv ----
// CAS voice signaling mapper: one station-side and one office-side analog port
// against the signaling nibbles of an E1 framer.
// Assumes the framer presents each port's received ABCD nibble with a one-cycle
// update strobe, and samples the transmitted nibbles whenever it needs them.
//
// What this block does
// - Station port hook indication is the chosen received A or B bit, 1 off hook, inverted on request.
// - Station port sends off hook as 1 and on hook as 0 on the chosen bit, inverted on request.
// - Station port fills every other transmitted ABCD bit from its four-bit default pattern, except the polarity lane, sent as 0 with polarity enabled.
// - With polarity enabled, polarity is received on B when hook uses A, and on A when hook uses B.
// - Office port hook indication is the chosen received A or B bit, 1 off hook, inverted on request.
// - Office port sends 1 while ringing is detected and 0 otherwise on the chosen bit, inverted on request.
// - Office port fills every other transmitted ABCD bit from its four-bit default pattern, except the polarity lane (0 with polarity enabled) and the echo lane.
// - With feedback enabled and the hook lane differing from the ring lane, the office port echoes the received hook signaling back to the link.
// - During out of service with the hold-on-hook method the office hook signaling stays on hook.
// - During out of service with the hold-off-hook method the office hook signaling stays off hook.
// - Voice channels on the E1 link use A-law companding.
//
// Decided for this implementation: the register offsets and strobed register access.
module cas_voice_signaling_mapper
  import cas_map_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_W,
  parameter int DATA_WIDTH = DATA_W
)
(
  input wire logic mclk_in, // System clock, 250 MHz
  input wire logic rst_in, // Asynchronous reset, active high
  input wire logic [ADDR_WIDTH-1:0] addr_in, // Register word address
  input wire logic [DATA_WIDTH-1:0] wdata_in, // Register write data
  input wire logic wr_in, // Register write strobe
  input wire logic rd_in, // Register read strobe
  output logic [DATA_WIDTH-1:0] rdata_out, // Read data, cycle after the strobe
  input wire logic [ABCD_W-1:0] st_rx_abcd_in, // Station port ABCD from the framer
  input wire logic st_rx_upd_in, // Station port nibble update strobe
  output logic [ABCD_W-1:0] st_tx_abcd_out, // Station port ABCD to the framer
  input wire logic st_line_off_hook_in, // Station line loop closed
  output logic st_hook_ind_out, // Station hook indication toward the line
  output logic st_polarity_out, // Station received polarity reversal
  input wire logic of_rx_abcd_upd_in, // Office port nibble update strobe
  input wire logic [ABCD_W-1:0] of_rx_abcd_in, // Office port ABCD from the framer
  output logic [ABCD_W-1:0] of_tx_abcd_out, // Office port ABCD to the framer
  input wire logic of_ring_det_in, // Office line ringing detected
  output logic of_hook_ind_out, // Office hook indication toward the line
  output logic of_polarity_out, // Office received polarity reversal
  input wire logic oos_in, // Link out-of-service condition
  output logic law_a_out // Companding law in use, 1 for A-law
);

  logic [DATA_WIDTH-1:0] st_cfg_reg;
  logic [DATA_WIDTH-1:0] of_cfg_reg;
  logic [DATA_WIDTH-1:0] rdata_next;
  logic [DATA_WIDTH-1:0] status_word;
  logic of_fb_raw_reg;
  logic st_hook_next;
  logic st_pol_next;
  logic of_hook_map;
  logic of_pol_next;
  logic of_hook_raw;
  logic [ABCD_W-1:0] st_tx_next;
  logic [ABCD_W-1:0] of_tx_next;

  // Picks the A or B bit of a nibble
  function automatic logic pick_ab(input logic [ABCD_W-1:0] abcd, input logic sel_b);
    pick_ab = sel_b ? abcd[BIT_B] : abcd[BIT_A];
  endfunction

  // Default fill, with the state bit on the chosen lane. The polarity lane,
  // when reserved, is sent as zero since the port only receives polarity.
  function automatic logic [ABCD_W-1:0] build_tx(
    input logic [ABCD_W-1:0] fill,
    input logic sel_b,
    input logic val,
    input logic pol_en,
    input logic pol_sel_b
  );
    logic [ABCD_W-1:0] word;
    word = fill;
    if (pol_en)
    begin
      if (pol_sel_b)
      begin
        word[BIT_B] = 1'b0;
      end
      else
      begin
        word[BIT_A] = 1'b0;
      end
    end
    if (sel_b)
    begin
      word[BIT_B] = val;
    end
    else
    begin
      word[BIT_A] = val;
    end
    build_tx = word;
  endfunction

  // Configuration registers
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_cfg_reg <= {{(DATA_WIDTH-CFG_DEF_MSB-1){1'b0}}, STATION_DEF_RST, {CFG_DEF_LSB{1'b0}}};
      of_cfg_reg <= {{(DATA_WIDTH-CFG_DEF_MSB-1){1'b0}}, OFFICE_DEF_RST, {CFG_DEF_LSB{1'b0}}};
    end
    else if (wr_in)
    begin
      if (addr_in == ADDR_STATION_CFG)
      begin
        st_cfg_reg <= wdata_in;
      end
      if (addr_in == ADDR_OFFICE_CFG)
      begin
        of_cfg_reg <= wdata_in;
      end
    end
  end

  // Status word
  always_comb
  begin
    status_word = '0;
    status_word[ST_STATION_HOOK] = st_hook_ind_out;
    status_word[ST_STATION_POL] = st_polarity_out;
    status_word[ST_OFFICE_HOOK] = of_hook_ind_out;
    status_word[ST_OFFICE_POL] = of_polarity_out;
    status_word[ST_OOS] = oos_in;
    status_word[ST_LAW_A] = LAW_A;
  end

  // Read mux; undefined addresses read as zero
  always_comb
  begin
    rdata_next = '0;
    if (rd_in)
    begin
      unique case (addr_in)
        ADDR_STATION_CFG: rdata_next = st_cfg_reg;
        ADDR_OFFICE_CFG: rdata_next = of_cfg_reg;
        ADDR_STATUS: rdata_next = status_word;
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata_out <= '0;
    end
    else
    begin
      rdata_out <= rdata_next;
    end
  end

  // Station port receive side
  always_comb
  begin
    st_hook_next = pick_ab(st_rx_abcd_in, st_cfg_reg[CFG_RX_SEL_B]) ^
                   st_cfg_reg[CFG_RX_INV];
    st_pol_next = st_cfg_reg[CFG_POL_EN] &
                  pick_ab(st_rx_abcd_in, ~st_cfg_reg[CFG_RX_SEL_B]);
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_hook_ind_out <= 1'b0;
      st_polarity_out <= 1'b0;
    end
    else if (st_rx_upd_in)
    begin
      st_hook_ind_out <= st_hook_next;
      st_polarity_out <= st_pol_next;
    end
    else if (!st_cfg_reg[CFG_POL_EN])
    begin
      st_polarity_out <= 1'b0;
    end
  end

  // Station port transmit side
  always_comb
  begin
    st_tx_next = build_tx(st_cfg_reg[CFG_DEF_MSB:CFG_DEF_LSB],
                          st_cfg_reg[CFG_TX_SEL_B],
                          st_line_off_hook_in ^ st_cfg_reg[CFG_TX_INV],
                          st_cfg_reg[CFG_POL_EN],
                          ~st_cfg_reg[CFG_RX_SEL_B]);
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_tx_abcd_out <= STATION_DEF_RST;
    end
    else
    begin
      st_tx_abcd_out <= st_tx_next;
    end
  end

  // Office port receive side
  always_comb
  begin
    of_hook_raw = pick_ab(of_rx_abcd_in, of_cfg_reg[CFG_RX_SEL_B]);
    of_hook_map = of_hook_raw ^ of_cfg_reg[CFG_RX_INV];
    of_pol_next = of_cfg_reg[CFG_POL_EN] &
                  pick_ab(of_rx_abcd_in, ~of_cfg_reg[CFG_RX_SEL_B]);
  end

  // Echo source is the hook bit of the last update: between updates the
  // framer's nibble is not valid, so a live echo would send garbage.
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      of_fb_raw_reg <= 1'b0;
    end
    else if (of_rx_abcd_upd_in)
    begin
      of_fb_raw_reg <= of_hook_raw;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      of_hook_ind_out <= 1'b0;
    end
    else if (oos_in)
    begin
      if (oos_method_t'(of_cfg_reg[CFG_OOS_OFF_HOOK]) == OOS_HOLD_OFF_HOOK)
      begin
        of_hook_ind_out <= 1'b1;
      end
      else
      begin
        of_hook_ind_out <= 1'b0;
      end
    end
    else if (of_rx_abcd_upd_in)
    begin
      of_hook_ind_out <= of_hook_map;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      of_polarity_out <= 1'b0;
    end
    else if (of_rx_abcd_upd_in)
    begin
      of_polarity_out <= of_pol_next;
    end
    else if (!of_cfg_reg[CFG_POL_EN])
    begin
      of_polarity_out <= 1'b0;
    end
  end

  // Office port transmit side. Feedback takes the hook lane only when it
  // differs from the ring lane; the ring state always keeps its own lane.
  always_comb
  begin
    of_tx_next = build_tx(of_cfg_reg[CFG_DEF_MSB:CFG_DEF_LSB],
                          of_cfg_reg[CFG_TX_SEL_B],
                          of_ring_det_in ^ of_cfg_reg[CFG_TX_INV],
                          of_cfg_reg[CFG_POL_EN],
                          ~of_cfg_reg[CFG_RX_SEL_B]);
    if (of_cfg_reg[CFG_FEEDBACK] && (of_cfg_reg[CFG_RX_SEL_B] != of_cfg_reg[CFG_TX_SEL_B]))
    begin
      if (of_cfg_reg[CFG_RX_SEL_B])
      begin
        of_tx_next[BIT_B] = of_fb_raw_reg;
      end
      else
      begin
        of_tx_next[BIT_A] = of_fb_raw_reg;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      of_tx_abcd_out <= OFFICE_DEF_RST;
    end
    else
    begin
      of_tx_abcd_out <= of_tx_next;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      law_a_out <= LAW_A;
    end
    else
    begin
      law_a_out <= LAW_A;
    end
  end

endmodule

// ---- verification/cas_map_sva.sv ----
// Checker for the CAS mapper, bound to the mapper's ports.
// Assumes configuration changes only through the register port.
module cas_map_checker
  import cas_map_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic [ABCD_W-1:0] st_rx_abcd_in,
  input wire logic st_rx_upd_in,
  input wire logic [ABCD_W-1:0] st_tx_abcd_out,
  input wire logic st_line_off_hook_in,
  input wire logic st_hook_ind_out,
  input wire logic st_polarity_out,
  input wire logic of_rx_abcd_upd_in,
  input wire logic [ABCD_W-1:0] of_rx_abcd_in,
  input wire logic [ABCD_W-1:0] of_tx_abcd_out,
  input wire logic of_ring_det_in,
  input wire logic of_hook_ind_out,
  input wire logic oos_in,
  input wire logic law_a_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] sc_reg;
  logic [DATA_W-1:0] oc_reg;
  logic [1:0] sr, st, orx, ot;
  logic s_hk, s_pl, o_hk, s_tb, o_tb;
  logic [3:0] s_m, o_m, s_df, o_df;
  // Shadow copies, so outputs can be judged against the live setup
  always_ff @(posedge mclk_in or posedge rst_in)
    if (rst_in)
      sc_reg <= 16'h0100;
    else if (wr_in && addr_in == ADDR_STATION_CFG)
      sc_reg <= wdata_in;
  always_ff @(posedge mclk_in or posedge rst_in)
    if (rst_in)
      oc_reg <= 16'h0000;
    else if (wr_in && addr_in == ADDR_OFFICE_CFG)
      oc_reg <= wdata_in;
  assign sr = 2'h3 - {1'b0, sc_reg[CFG_RX_SEL_B]};
  assign st = 2'h3 - {1'b0, sc_reg[CFG_TX_SEL_B]};
  assign orx = 2'h3 - {1'b0, oc_reg[CFG_RX_SEL_B]};
  assign ot = 2'h3 - {1'b0, oc_reg[CFG_TX_SEL_B]};
  assign s_hk = st_rx_abcd_in[sr] ^ sc_reg[CFG_RX_INV];
  assign s_pl = st_rx_abcd_in[sr ^ 2'h1];
  assign o_hk = of_rx_abcd_in[orx] ^ oc_reg[CFG_RX_INV];
  assign s_tb = st_line_off_hook_in ^ sc_reg[CFG_TX_INV];
  assign o_tb = of_ring_det_in ^ oc_reg[CFG_TX_INV];
  assign s_m = ~(4'h1 << st) & ~({3'h0, sc_reg[CFG_POL_EN]} << (sr ^ 2'h1));
  assign o_m = ~(4'h1 << ot) & ~({3'h0, oc_reg[CFG_POL_EN]} << (orx ^ 2'h1));
  assign s_df = sc_reg[CFG_DEF_MSB:CFG_DEF_LSB] & s_m;
  assign o_df = oc_reg[CFG_DEF_MSB:CFG_DEF_LSB] & o_m;
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  law_fixed_a: assert property (law_a_out == LAW_A)
    else $error("companding flag not A-law");
  st_hook_a: assert property (st_rx_upd_in |=> st_hook_ind_out == $past(s_hk))
    else $error("station hook indication wrong");
  st_pol_a: assert property (st_rx_upd_in && sc_reg[CFG_POL_EN] |=>
    st_polarity_out == $past(s_pl))
    else $error("station polarity lane wrong");
  st_lane_a: assert property (!$past(rst_in) |->
    st_tx_abcd_out[$past(st)] == $past(s_tb))
    else $error("station hook bit wrong");
  st_fill_a: assert property (!$past(rst_in) |->
    (st_tx_abcd_out & $past(s_m)) == $past(s_df))
    else $error("station fill bits wrong");
  of_lane_a: assert property (!$past(rst_in) |->
    of_tx_abcd_out[$past(ot)] == $past(o_tb))
    else $error("office ring bit wrong");
  of_fill_a: assert property (!$past(rst_in) && !$past(oc_reg[CFG_FEEDBACK]) |->
    (of_tx_abcd_out & $past(o_m)) == $past(o_df))
    else $error("office fill bits wrong");
  of_hook_a: assert property (of_rx_abcd_upd_in && !oos_in |=>
    of_hook_ind_out == $past(o_hk))
    else $error("office hook indication wrong");
  oos_on_a: assert property (oos_in && !oc_reg[CFG_OOS_OFF_HOOK] |=> !of_hook_ind_out)
    else $error("office hook not held on hook");
  oos_off_a: assert property (oos_in && oc_reg[CFG_OOS_OFF_HOOK] |=> of_hook_ind_out)
    else $error("office hook not held off hook");
  oos_c: cover property (oos_in && oc_reg[CFG_OOS_OFF_HOOK]);
  pol_c: cover property (st_rx_upd_in && sc_reg[CFG_POL_EN]);
  fb_c: cover property (of_rx_abcd_upd_in && oc_reg[CFG_FEEDBACK]);
endmodule

// ---- verification/e1_framer_model.sv ----
// Framer model: received nibbles with a one-cycle update strobe, and the service flag.
// Assumes the bench calls its tasks; a nibble not being updated shows its inverse.
module e1_framer_model
  import cas_map_pkg::*;
(
  input wire logic clk_in, // System clock
  output logic [ABCD_W-1:0] st_abcd_out, // Station nibble
  output logic st_upd_out, // Station update strobe
  output logic [ABCD_W-1:0] of_abcd_out, // Office nibble
  output logic of_upd_out, // Office update strobe
  output logic oos_out // Out of service
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    st_abcd_out = 4'h0;
    st_upd_out = 1'b0;
    of_abcd_out = 4'h0;
    of_upd_out = 1'b0;
    oos_out = 1'b0;
  end
  task automatic send(input logic [ABCD_W-1:0] sv, input logic [ABCD_W-1:0] ov);
    @(posedge clk_in);
    st_abcd_out <= sv;
    of_abcd_out <= ov;
    st_upd_out <= 1'b1;
    of_upd_out <= 1'b1;
    @(posedge clk_in);
    st_upd_out <= 1'b0;
    of_upd_out <= 1'b0;
    st_abcd_out <= ~sv;
    of_abcd_out <= ~ov;
  endtask
  // Extra cycle lets the registered office hook indication follow the service flag
  task automatic set_oos(input logic v);
    @(posedge clk_in);
    oos_out <= v;
    @(posedge clk_in);
  endtask
endmodule

// ---- verification/cas_voice_signaling_mapper_test.sv ----
// Self-checking bench for the CAS mapper with a framer model on the link side.
// Assumes the status word mirrors the hook, polarity and service outputs.
module cas_voice_signaling_mapper_test
  import cas_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [DATA_W-1:0] wdata_in = '0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic st_line_off_hook_in = 1'b0;
  logic of_ring_det_in = 1'b0;
  logic [DATA_W-1:0] rdata_out;
  logic [ABCD_W-1:0] st_rx_abcd_in, st_tx_abcd_out, of_rx_abcd_in, of_tx_abcd_out;
  logic st_rx_upd_in, of_rx_abcd_upd_in, oos_in, st_hook_ind_out, st_polarity_out;
  logic of_hook_ind_out, of_polarity_out, law_a_out;
  logic rd_d = 1'b0;
  logic [15:0] sc = 16'h0100;
  logic [15:0] oc = 16'h0000;
  logic [3:0] ol = 4'h0;
  logic sh = 0, sp = 0, oh = 0, op = 0, oosv = 0;
  logic [23:0] q[$];
  int n_mismatch = 0;
  int comparisons = 0;
  int i;
  function automatic logic [3:0] tx_ex(logic [15:0] c, logic h, logic f);
    logic [3:0] t;
    t = c[11:8];
    if (c[4])
      t[c[0] ? 3 : 2] = 1'b0;
    if (c[5] && c[0] != c[2])
      t[c[0] ? 2 : 3] = f;
    t[c[2] ? 2 : 3] = h ^ c[3];
    return t;
  endfunction
  task automatic check(string w, logic [23:0] s, logic [23:0] e);
    comparisons++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wrr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    if (a == ADDR_STATION_CFG) sc = d;
    if (a == ADDR_OFFICE_CFG) oc = d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    q.push_back({tx_ex(sc, st_line_off_hook_in, 1'b0),
      tx_ex(oc, of_ring_det_in, ol[oc[0] ? 2 : 3]), d});
    @(posedge mclk_in);
    rd_in <= 1'b0;
  endtask
  task automatic look;
    rdc(ADDR_STATUS, {10'h0, LAW_A, oosv, op, oh, sp, sh});
  endtask
  task automatic upd(input logic [3:0] sv, input logic [3:0] ov);
    fr.send(sv, ov);
    sh = sv[sc[0] ? 2 : 3] ^ sc[1];
    sp = sc[4] & sv[sc[0] ? 3 : 2];
    ol = ov;
    oh = oosv ? oc[6] : ov[oc[0] ? 2 : 3] ^ oc[1];
    op = oc[4] & ov[oc[0] ? 3 : 2];
  endtask
  initial
  begin
    forever #2 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in)
    rd_d <= rd_in;
  // Read data stand only in the cycle after the strobe
  always @(negedge mclk_in)
    if (rd_d)
    begin
      check("tx and read data",
        {st_tx_abcd_out, of_tx_abcd_out, rdata_out}, q.pop_front());
      check("coding law", {23'h0, law_a_out}, {23'h0, LAW_A});
    end
  initial
  begin
    repeat (20000) @(posedge mclk_in);
    n_mismatch++;
    results();
  end
  initial
  begin
    i = $urandom(50);
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    rdc(ADDR_STATION_CFG, 16'h0100);
    rdc(ADDR_OFFICE_CFG, 16'h0000);
    rdc(4'hF, 16'h0000);
    wrr(ADDR_STATUS, 16'hFFFF);
    look();
    $display("test registers done");
    for (i = 0; i < 64; i++)
    begin
      wrr(ADDR_STATION_CFG, {4'h0, 4'($urandom), 3'h0, i[4:0]});
      wrr(ADDR_OFFICE_CFG, {4'h0, 4'($urandom), 2'h0, i[5:0]});
      upd(4'($urandom), 4'($urandom));
      st_line_off_hook_in <= 1'($urandom);
      of_ring_det_in <= 1'($urandom);
      look();
    end
    $display("test mapping done");
    for (i = 0; i < 2; i++)
    begin
      wrr(ADDR_OFFICE_CFG, {9'h0, i[0], 6'h0});
      fr.set_oos(1'b1);
      oosv = 1'b1;
      upd(4'($urandom), {~i[0], 3'h2});
      look();
      fr.set_oos(1'b0);
      oosv = 1'b0;
      look();
      upd(4'($urandom), {~i[0], 3'h5});
      look();
    end
    $display("test out of service done");
    results();
  end
  cas_voice_signaling_mapper uut (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .st_rx_abcd_in(st_rx_abcd_in),
    .st_rx_upd_in(st_rx_upd_in),
    .st_tx_abcd_out(st_tx_abcd_out),
    .st_line_off_hook_in(st_line_off_hook_in),
    .st_hook_ind_out(st_hook_ind_out),
    .st_polarity_out(st_polarity_out),
    .of_rx_abcd_upd_in(of_rx_abcd_upd_in),
    .of_rx_abcd_in(of_rx_abcd_in),
    .of_tx_abcd_out(of_tx_abcd_out),
    .of_ring_det_in(of_ring_det_in),
    .of_hook_ind_out(of_hook_ind_out),
    .of_polarity_out(of_polarity_out),
    .oos_in(oos_in),
    .law_a_out(law_a_out)
  );
  e1_framer_model fr (
    .clk_in(mclk_in),
    .st_abcd_out(st_rx_abcd_in),
    .st_upd_out(st_rx_upd_in),
    .of_abcd_out(of_rx_abcd_in),
    .of_upd_out(of_rx_abcd_upd_in),
    .oos_out(oos_in)
  );
endmodule
bind cas_voice_signaling_mapper cas_map_checker chk (.*);
